// [rtl/tcoc_top.sv]
/*
 * Compare-output control of a 16-bit timer: control registers, byte-wise
 * access to the 16-bit counter, compare and capture registers through one
 * shared high-byte holding register, and the two waveform pins.
 * Assumes the counter, prescaler and capture logic sit outside and hand in
 * tick, match, top, direction, count and capture strobes on mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module tcoc_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // cpu i/o bus
    input  wire logic [5:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    output var  logic [7:0]  io_rdata,
    // counter unit side
    input  wire logic        tmr_tick,
    input  wire logic        match_a,
    input  wire logic        match_b,
    input  wire logic        at_top,
    input  wire logic        count_down,
    input  wire logic [15:0] counter_value,
    input  wire logic        cap_load,
    input  wire logic [15:0] cap_data,
    output var  logic [3:0]  wave_mode,
    output var  logic [7:0]  timer_ctrl_b,
    output var  logic [15:0] compare_value_a,
    output var  logic [15:0] compare_value_b,
    output var  logic [15:0] capture_value,
    output var  logic        cnt_load,
    output var  logic [15:0] cnt_load_value,
    // normal port function of the two pins
    input  wire logic        port_a_out,
    input  wire logic        port_a_dir,
    input  wire logic        port_b_out,
    input  wire logic        port_b_dir,
    // pins
    output var  logic        wave_out_a,
    output var  logic        wave_out_a_oe_n,
    output var  logic        wave_out_b,
    output var  logic        wave_out_b_oe_n
);
    import tcoc_pkg::*;

    logic [7:0]  ctrl_a_q,  ctrl_a_d;
    logic [7:0]  ctrl_b_q,  ctrl_b_d;
    logic [7:0]  hold_q,    hold_d;
    logic [15:0] cmp_a_q,   cmp_a_d;
    logic [15:0] cmp_b_q,   cmp_b_d;
    logic [15:0] cap_q,     cap_d;
    logic        cld_q,     cld_d;
    logic [15:0] cldv_q,    cldv_d;
    logic [7:0]  rdata_q,   rdata_d;
    logic        pa_q,      pa_d;
    logic        pb_q,      pb_d;
    logic        pa_oe_n_q, pa_oe_n_d;
    logic        pb_oe_n_q, pb_oe_n_d;
    logic [3:0]  mode;
    logic [15:0] top_val;
    tcoc_class_t cls;

    tcoc_chan_if ch_a ();
    tcoc_chan_if ch_b ();

    ////////////////////////////////////////////////////////////////////////////
    // mode decode shared by both channels
    assign mode    = {ctrl_b_q[`TCOC_WMH_MSB:`TCOC_WMH_LSB], ctrl_a_q[`TCOC_WML_MSB:`TCOC_WML_LSB]};
    assign cls     = tcoc_class_of(mode);
    assign top_val = tcoc_top_of(mode, cmp_a_q, cap_q);

    // channel a drive
    assign ch_a.out_mode   = ctrl_a_q[`TCOC_COMA_MSB:`TCOC_COMA_LSB];
    assign ch_a.cls        = cls;
    assign ch_a.top_bit    = mode[`TCOC_WM_TOP_BIT];
    assign ch_a.is_a       = 1'b1;
    assign ch_a.tick       = tmr_tick;
    assign ch_a.match      = match_a;
    assign ch_a.at_top     = at_top;
    assign ch_a.count_down = count_down;
    assign ch_a.cmp_is_top = (cmp_a_q == top_val);

    // channel b drive
    assign ch_b.out_mode   = ctrl_a_q[`TCOC_COMB_MSB:`TCOC_COMB_LSB];
    assign ch_b.cls        = cls;
    assign ch_b.top_bit    = mode[`TCOC_WM_TOP_BIT];
    assign ch_b.is_a       = 1'b0;
    assign ch_b.tick       = tmr_tick;
    assign ch_b.match      = match_b;
    assign ch_b.at_top     = at_top;
    assign ch_b.count_down = count_down;
    assign ch_b.cmp_is_top = (cmp_b_q == top_val);

    tcoc_chan u_chan_a (
        .mclk (mclk),
        .rst  (rst),
        .ch   (ch_a.unit)
    );

    tcoc_chan u_chan_b (
        .mclk (mclk),
        .rst  (rst),
        .ch   (ch_b.unit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register file: writes, holding register, capture loads
    always_comb begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        hold_d   = hold_q;
        cmp_a_d  = cmp_a_q;
        cmp_b_d  = cmp_b_q;
        cap_d    = cap_q;
        cld_d    = 1'b0;
        cldv_d   = cldv_q;
        if (io_wr) begin
            case (io_addr)
                `TCOC_ADR_CTRL_A: ctrl_a_d = io_wdata & `TCOC_CTRL_A_WMASK;
                `TCOC_ADR_CTRL_B: ctrl_b_d = io_wdata & `TCOC_CTRL_B_WMASK;
                // every high-byte address lands in the one holding register
                `TCOC_ADR_CNT_H, `TCOC_ADR_CMPA_H,
                `TCOC_ADR_CMPB_H, `TCOC_ADR_CAP_H: hold_d = io_wdata;
                // low write commits both bytes; holding register is kept
                `TCOC_ADR_CNT_L: begin
                    cld_d  = 1'b1;
                    cldv_d = {hold_q, io_wdata};
                end
                `TCOC_ADR_CMPA_L: cmp_a_d = {hold_q, io_wdata};
                `TCOC_ADR_CMPB_L: cmp_b_d = {hold_q, io_wdata};
                `TCOC_ADR_CAP_L:  cap_d   = {hold_q, io_wdata};
                default: ;
            endcase
        end else if (io_rd) begin
            // low read of counter or capture latches the high byte
            case (io_addr)
                `TCOC_ADR_CNT_L: hold_d = counter_value[15:8];
                `TCOC_ADR_CAP_L: hold_d = cap_q[15:8];
                default: ;  // compare reads leave the holding register alone
            endcase
        end
        // a capture event beats a software write in the same cycle
        if (cap_load) begin
            cap_d = cap_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_a_q <= `TCOC_RST8;
            ctrl_b_q <= `TCOC_RST8;
            hold_q   <= `TCOC_RST8;
            cmp_a_q  <= `TCOC_RST16;
            cmp_b_q  <= `TCOC_RST16;
            cap_q    <= `TCOC_RST16;
            cld_q    <= 1'b0;
            cldv_q   <= `TCOC_RST16;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            hold_q   <= hold_d;
            cmp_a_q  <= cmp_a_d;
            cmp_b_q  <= cmp_b_d;
            cap_q    <= cap_d;
            cld_q    <= cld_d;
            cldv_q   <= cldv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (io_rd) begin
            case (io_addr)
                `TCOC_ADR_CTRL_A: rdata_d = ctrl_a_q;
                `TCOC_ADR_CTRL_B: rdata_d = ctrl_b_q;
                `TCOC_ADR_CNT_L:  rdata_d = counter_value[7:0];
                `TCOC_ADR_CNT_H:  rdata_d = hold_q;
                `TCOC_ADR_CAP_L:  rdata_d = cap_q[7:0];
                `TCOC_ADR_CAP_H:  rdata_d = hold_q;
                `TCOC_ADR_CMPA_L: rdata_d = cmp_a_q[7:0];
                `TCOC_ADR_CMPA_H: rdata_d = cmp_a_q[15:8];
                `TCOC_ADR_CMPB_L: rdata_d = cmp_b_q[7:0];
                `TCOC_ADR_CMPB_H: rdata_d = cmp_b_q[15:8];
                default:          rdata_d = `TCOC_RST8;
            endcase
        end
    end

    // pin muxes; register stage keeps the pins glitch free
    always_comb begin
        pa_d      = ch_a.connected ? ch_a.wave : port_a_out;
        pb_d      = ch_b.connected ? ch_b.wave : port_b_out;
        pa_oe_n_d = ~port_a_dir;
        pb_oe_n_d = ~port_b_dir;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q   <= `TCOC_RST8;
            pa_q      <= 1'b0;
            pb_q      <= 1'b0;
            pa_oe_n_q <= 1'b1;
            pb_oe_n_q <= 1'b1;
        end else begin
            rdata_q   <= rdata_d;
            pa_q      <= pa_d;
            pb_q      <= pb_d;
            pa_oe_n_q <= pa_oe_n_d;
            pb_oe_n_q <= pb_oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    assign io_rdata        = rdata_q;
    assign wave_mode       = mode;
    assign timer_ctrl_b    = ctrl_b_q;
    assign compare_value_a = cmp_a_q;
    assign compare_value_b = cmp_b_q;
    assign capture_value   = cap_q;
    assign cnt_load        = cld_q;
    assign cnt_load_value  = cldv_q;
    assign wave_out_a      = pa_q;
    assign wave_out_a_oe_n = pa_oe_n_q;
    assign wave_out_b      = pb_q;
    assign wave_out_b_oe_n = pb_oe_n_q;
endmodule : tcoc_top

`default_nettype wire

// [rtl/tcoc_cfg.svh]
/*
 * Constants of the timer compare-output control block: I/O addresses, field
 * positions, write masks, reset values, fixed top values and field codes.
 * Assumes a 6-bit I/O address space and an 8-bit data bus.
 */
`ifndef TCOC_CFG_SVH
`define TCOC_CFG_SVH

// i/o addresses
`define TCOC_ADR_CTRL_A   6'h2f
`define TCOC_ADR_CTRL_B   6'h2e
`define TCOC_ADR_CNT_L    6'h2c
`define TCOC_ADR_CNT_H    6'h2d
`define TCOC_ADR_CMPA_L   6'h2a
`define TCOC_ADR_CMPA_H   6'h2b
`define TCOC_ADR_CMPB_L   6'h28
`define TCOC_ADR_CMPB_H   6'h29
`define TCOC_ADR_CAP_L    6'h24
`define TCOC_ADR_CAP_H    6'h25

// field positions in the first control register
`define TCOC_COMA_MSB     7
`define TCOC_COMA_LSB     6
`define TCOC_COMB_MSB     5
`define TCOC_COMB_LSB     4
`define TCOC_WML_MSB      1
`define TCOC_WML_LSB      0
// field positions in the second control register; the top bit is a position in the 4-bit mode
`define TCOC_WMH_MSB      4
`define TCOC_WMH_LSB      3
`define TCOC_WM_TOP_BIT   3

// writable bits; the rest read as zero
`define TCOC_CTRL_A_WMASK 8'hf3
`define TCOC_CTRL_B_WMASK 8'hdf

// reset values
`define TCOC_RST8         8'h00
`define TCOC_RST16        16'h0000

// fixed top values
`define TCOC_TOP_8BIT     16'h00ff
`define TCOC_TOP_9BIT     16'h01ff
`define TCOC_TOP_10BIT    16'h03ff
`define TCOC_TOP_MAX      16'hffff

// compare-output field codes
`define TCOC_COM_OFF      2'h0
`define TCOC_COM_TOG      2'h1
`define TCOC_COM_CLR      2'h2
`define TCOC_COM_SET      2'h3

`endif

// [rtl/tcoc_pkg.sv]
/*
 * Types and helper functions of the timer compare-output control block.
 * Assumes tcoc_cfg.svh is on the include path.
 */
`include "tcoc_cfg.svh"

package tcoc_pkg;

    // how the compare-output field is read
    typedef enum logic [1:0] {
        tcoc_cls_nonpwm,
        tcoc_cls_fast,
        tcoc_cls_phase,
        tcoc_cls_rsvd
    } tcoc_class_t;

    // waveform mode to interpretation class
    function automatic tcoc_class_t tcoc_class_of(input logic [3:0] mode);
        case (mode)
            4'h0, 4'h4, 4'hc:             tcoc_class_of = tcoc_cls_nonpwm;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: tcoc_class_of = tcoc_cls_fast;
            4'hd:                         tcoc_class_of = tcoc_cls_rsvd;
            default:                      tcoc_class_of = tcoc_cls_phase;
        endcase
    endfunction : tcoc_class_of

    // top value of the count for each mode
    function automatic logic [15:0] tcoc_top_of(input logic [3:0]  mode,
                                                 input logic [15:0] cmp_a,
                                                 input logic [15:0] cap);
        case (mode)
            4'h1, 4'h5:             tcoc_top_of = `TCOC_TOP_8BIT;
            4'h2, 4'h6:             tcoc_top_of = `TCOC_TOP_9BIT;
            4'h3, 4'h7:             tcoc_top_of = `TCOC_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: tcoc_top_of = cmp_a;
            4'h8, 4'ha, 4'hc, 4'he: tcoc_top_of = cap;
            default:                tcoc_top_of = `TCOC_TOP_MAX;
        endcase
    endfunction : tcoc_top_of

endpackage : tcoc_pkg

// [rtl/tcoc_chan_if.sv]
/*
 * Carrier between the control top and one compare-output channel unit.
 * Assumes tcoc_pkg is compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

interface tcoc_chan_if;
    import tcoc_pkg::*;

    logic [1:0]  out_mode;
    tcoc_class_t cls;
    logic        top_bit;
    logic        is_a;
    logic        tick;
    logic        match;
    logic        at_top;
    logic        count_down;
    logic        cmp_is_top;
    logic        wave;
    logic        connected;

    modport ctl  (output out_mode, cls, top_bit, is_a, tick, match, at_top, count_down, cmp_is_top,
                  input  wave, connected);
    modport unit (input  out_mode, cls, top_bit, is_a, tick, match, at_top, count_down, cmp_is_top,
                  output wave, connected);
endinterface : tcoc_chan_if

`default_nettype wire

// [rtl/tcoc_chan.sv]
/*
 * One compare-output channel: holds the waveform bit and moves it on compare
 * matches and top events as the field and class say.
 * Assumes match and top strobes are single cycles qualified by tick.
 */
`timescale 1ns/10ps
`default_nettype none

module tcoc_chan (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // channel carrier
    tcoc_chan_if.unit   ch
);
    import tcoc_pkg::*;

    logic wave_q;
    logic wave_d;
    logic pwm;
    logic tog_ok;

    ////////////////////////////////////////////////////////////////////////////
    // toggle is legal in non-pwm, or in fast or phase class on channel a with the top mode bit
    assign pwm    = (ch.cls == tcoc_cls_fast) || (ch.cls == tcoc_cls_phase);
    assign tog_ok = (ch.cls == tcoc_cls_nonpwm) || (pwm && ch.top_bit && ch.is_a);

    // pin takeover; in fast or phase class a toggle code without toggle rights stays disconnected
    assign ch.connected = (ch.out_mode != `TCOC_COM_OFF)
                          && !(pwm && (ch.out_mode == `TCOC_COM_TOG) && !tog_ok);
    assign ch.wave      = wave_q;

    ////////////////////////////////////////////////////////////////////////////
    // next waveform bit; default holds, field writes alone never move it
    always_comb begin
        wave_d = wave_q;
        if (ch.tick) begin
            case (ch.cls)
                tcoc_cls_nonpwm: begin
                    if (ch.match) begin
                        case (ch.out_mode)
                            `TCOC_COM_TOG: wave_d = ~wave_q;
                            `TCOC_COM_CLR: wave_d = 1'b0;
                            `TCOC_COM_SET: wave_d = 1'b1;
                            default:       wave_d = wave_q;
                        endcase
                    end
                end
                tcoc_cls_fast: begin
                    // a match at the top value is dropped when the upper bit is set
                    if (ch.match && !(ch.cmp_is_top && ch.out_mode[1])) begin
                        case (ch.out_mode)
                            `TCOC_COM_TOG: wave_d = tog_ok ? ~wave_q : wave_q;
                            `TCOC_COM_CLR: wave_d = 1'b0;
                            `TCOC_COM_SET: wave_d = 1'b1;
                            default:       wave_d = wave_q;
                        endcase
                    end
                    if (ch.at_top) begin
                        case (ch.out_mode)
                            `TCOC_COM_CLR: wave_d = 1'b1;
                            `TCOC_COM_SET: wave_d = 1'b0;
                            default: ;
                        endcase
                    end
                end
                tcoc_cls_phase: begin
                    if (ch.match) begin
                        case (ch.out_mode)
                            `TCOC_COM_TOG: wave_d = tog_ok ? ~wave_q : wave_q;
                            `TCOC_COM_CLR: wave_d = ch.count_down;
                            `TCOC_COM_SET: wave_d = ~ch.count_down;
                            default:       wave_d = wave_q;
                        endcase
                    end
                end
                default: wave_d = wave_q;  // reserved mode leaves the bit alone
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end
endmodule : tcoc_chan

`default_nettype wire

// [sim/tcoc_top_props.sv]
/* checker: bus, pin and waveform relations of tcoc_top.
   assumes it is bound to tcoc_top and sees all cpu writes. */
`timescale 1ns/10ps
`default_nettype none
`include "tcoc_cfg.svh"

module tcoc_top_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // cpu bus
    input wire logic [5:0]  io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    // counter side
    input wire logic        tmr_tick,
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        at_top,
    input wire logic        count_down,
    input wire logic [15:0] counter_value,
    input wire logic [3:0]  wave_mode,
    input wire logic [15:0] compare_value_a,
    input wire logic [15:0] compare_value_b,
    // pins
    input wire logic        port_a_out,
    input wire logic        port_a_dir,
    input wire logic        wave_out_a,
    input wire logic        wave_out_a_oe_n,
    input wire logic        wave_out_b
);
    logic [7:0] ctl_q;
    logic [7:0] hold_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // shadow of ctrl a and the holding byte; capture reads are not tracked
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q  <= 8'h00;
            hold_q <= 8'h00;
        end else if (io_wr) begin
            if (io_addr == `TCOC_ADR_CTRL_A) ctl_q <= io_wdata & `TCOC_CTRL_A_WMASK;
            if (io_addr[0] && io_addr != `TCOC_ADR_CTRL_A) hold_q <= io_wdata;
        end else if (io_rd && io_addr == `TCOC_ADR_CNT_L) begin
            hold_q <= counter_value[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_oe_a; port_a_dir |=> !wave_out_a_oe_n; endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a driver off");
    property p_rsvd; io_rd && !io_wr && io_addr == `TCOC_ADR_CTRL_A |=> io_rdata[3:2] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("ctrl a bits 3:2 not zero");
    property p_cmpa;
        io_wr && io_addr == `TCOC_ADR_CMPA_L |=> compare_value_a == {$past(hold_q), $past(io_wdata)};
    endproperty
    a_cmpa: assert property (p_cmpa) else $error("compare a load wrong");
    property p_cmpb;
        io_wr && io_addr == `TCOC_ADR_CMPB_L |=> compare_value_b == {$past(hold_q), $past(io_wdata)};
    endproperty
    a_cmpb: assert property (p_cmpb) else $error("compare b load wrong");
    property p_mode; io_wr && io_addr == `TCOC_ADR_CTRL_A |=> wave_mode[1:0] == $past(io_wdata[1:0]); endproperty
    a_mode: assert property (p_mode) else $error("mode low bits wrong");
    property p_disc; ctl_q[7:6] == 2'h0 |=> wave_out_a == $past(port_a_out); endproperty
    a_disc: assert property (p_disc) else $error("pin a not port data");
    property p_nonpwm; wave_mode == 4'h0 && ctl_q[7:6] == 2'h3 && tmr_tick && match_a |-> ##2 wave_out_a; endproperty
    a_nonpwm: assert property (p_nonpwm) else $error("set on match failed");
    property p_fast; wave_mode == 4'h5 && ctl_q[5:4] == 2'h2 && tmr_tick && at_top |-> ##2 wave_out_b; endproperty
    a_fast: assert property (p_fast) else $error("set at top failed");
    property p_phase;
        wave_mode == 4'h1 && ctl_q[5:4] == 2'h2 && tmr_tick && match_b && !count_down |-> ##2 !wave_out_b;
    endproperty
    a_phase: assert property (p_phase) else $error("clear on up match failed");

    c_match: cover property (tmr_tick && match_a);
    c_top: cover property (tmr_tick && at_top);
    c_cntrd: cover property (io_rd && io_addr == `TCOC_ADR_CNT_L);
endmodule : tcoc_top_props

bind tcoc_top tcoc_top_props i_props (.mclk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .tmr_tick, .match_a, .match_b, .at_top, .count_down, .counter_value, .wave_mode,
    .compare_value_a, .compare_value_b, .port_a_out, .port_a_dir, .wave_out_a, .wave_out_a_oe_n,
    .wave_out_b);

`default_nettype wire

// [sim/tcoc_cpu_model.sv]
/* cpu core model: byte accesses on the i/o bus, 16-bit pairs in order.
   assumes inputs change on the falling edge of mclk. */
`timescale 1ns/10ps
`default_nettype none

module tcoc_cpu_model (
    // clock
    input  wire logic       mclk,
    // cpu bus
    output var  logic [5:0] io_addr,
    output var  logic [7:0] io_wdata,
    output var  logic       io_wr,
    output var  logic       io_rd,
    input  wire logic [7:0] io_rdata
);
    initial begin
        io_addr  = 6'h00;
        io_wdata = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
    end

    // released bus shows inverted data so stale values never look valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge mclk);
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge mclk);
        io_rd   = 1'b0;
        io_addr = ~a;
        d       = io_rdata;
    endtask : rd

    // accesses are strictly sequential, no handler can slip
    task automatic wr16(input logic [5:0] a_lo, input logic [15:0] d);
        wr(a_lo + 6'h01, d[15:8]);
        wr(a_lo, d[7:0]);
    endtask : wr16
endmodule : tcoc_cpu_model

`default_nettype wire

// [sim/test_timer16_compare_output_control.sv]
/* testbench of tcoc_top: registers, holding byte and both waveform pins.
   assumes the cpu model and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "tcoc_cfg.svh"

module test_timer16_compare_output_control;
    logic mclk = 1'b0, rst, io_wr, io_rd, tmr_tick, match_a, match_b, at_top, count_down, cap_load, cnt_load;
    logic port_a_out, port_a_dir, port_b_out, port_b_dir;
    logic wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n;
    logic [5:0]  io_addr;
    logic [7:0]  io_wdata, io_rdata, timer_ctrl_b, v;
    logic [3:0]  wave_mode;
    logic [15:0] counter_value, cap_data, compare_value_a, compare_value_b, capture_value, cnt_load_value;
    int          failures, total_checks, cycles;

    tcoc_cpu_model i_cpu (.mclk, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata);
    tcoc_top i_dut (.mclk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .tmr_tick, .match_a,
        .match_b, .at_top, .count_down, .counter_value, .cap_load, .cap_data, .wave_mode, .timer_ctrl_b,
        .compare_value_a, .compare_value_b, .capture_value, .cnt_load, .cnt_load_value, .port_a_out,
        .port_a_dir, .port_b_out, .port_b_dir, .wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // one timer event, then wait until the registered pin has moved
    task automatic ev(input logic [3:0] e);
        @(negedge mclk);
        {match_a, match_b, at_top, count_down} = e;
        tmr_tick = 1'b1;
        @(negedge mclk);
        {match_a, match_b, at_top} = 3'h0;
        tmr_tick = 1'b0;
        @(negedge mclk);
    endtask : ev

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // a hang costs a mismatch and ends the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        rst = 1'b1;
        {tmr_tick, match_a, match_b, at_top, count_down, cap_load} = 6'h00;
        {port_a_out, port_a_dir, port_b_out, port_b_dir} = 4'hf;
        counter_value = 16'habcd;
        cap_data = 16'h0000;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        i_cpu.rd(`TCOC_ADR_CTRL_A, v); chk({8'h00, v}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'hff);
        i_cpu.rd(`TCOC_ADR_CTRL_A, v); chk({8'h00, v}, 16'h00f3);
        chk({12'h000, wave_mode}, 16'h0003);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h00);
        // counter: load pair, then low read latches the high byte
        i_cpu.wr16(`TCOC_ADR_CNT_L, 16'h01ff); chk(cnt_load_value, 16'h01ff);
        chk({15'h0, cnt_load}, 16'h0001);
        i_cpu.rd(`TCOC_ADR_CNT_L, v); chk({8'h00, v}, 16'h00cd);
        counter_value = 16'h0000;
        i_cpu.rd(`TCOC_ADR_CMPA_L, v); chk({8'h00, v}, 16'h0000);
        i_cpu.rd(`TCOC_ADR_CNT_H, v); chk({8'h00, v}, 16'h00ab);
        cap_data = 16'h5a3c; cap_load = 1'b1; @(negedge mclk); cap_load = 1'b0;
        chk(capture_value, 16'h5a3c); i_cpu.rd(`TCOC_ADR_CAP_L, v);
        i_cpu.rd(`TCOC_ADR_CAP_H, v); chk({8'h00, v}, 16'h005a);
        // compare registers and reuse of the holding byte
        i_cpu.wr16(`TCOC_ADR_CMPA_L, 16'h1234); chk(compare_value_a, 16'h1234);
        i_cpu.wr(`TCOC_ADR_CMPB_L, 8'h56); chk(compare_value_b, 16'h1256);
        i_cpu.rd(`TCOC_ADR_CMPA_H, v); chk({8'h00, v}, 16'h0012);
        // channel a, non-pwm, then toggle in fast pwm mode 15
        chk({14'h0, wave_out_a_oe_n, wave_out_b_oe_n}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'hc0); ev(4'h8); chk({15'h0, wave_out_a}, 16'h0001);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h80); @(negedge mclk); chk({15'h0, wave_out_a}, 16'h0001);
        ev(4'h8); chk({15'h0, wave_out_a}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h40); ev(4'h8); chk({15'h0, wave_out_a}, 16'h0001);
        ev(4'h8); chk({15'h0, wave_out_a}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h00); @(negedge mclk); chk({15'h0, wave_out_a}, 16'h0001);
        port_a_out = 1'b0;
        i_cpu.wr(`TCOC_ADR_CTRL_B, 8'hff);
        chk({8'h00, timer_ctrl_b}, 16'h00df);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h43); ev(4'h8); chk({15'h0, wave_out_a}, 16'h0001);
        port_a_dir = 1'b0;
        repeat (2) @(negedge mclk);
        chk({15'h0, wave_out_a_oe_n}, 16'h0001);
        // channel b, fast pwm 8-bit
        port_b_out = 1'b0;
        i_cpu.wr(`TCOC_ADR_CTRL_B, 8'h08);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h21); ev(4'h2); chk({15'h0, wave_out_b}, 16'h0001);
        ev(4'h4); chk({15'h0, wave_out_b}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h31); ev(4'h4); chk({15'h0, wave_out_b}, 16'h0001);
        ev(4'h2); chk({15'h0, wave_out_b}, 16'h0000);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h21);
        i_cpu.wr16(`TCOC_ADR_CMPB_L, 16'h00ff); ev(4'h2); ev(4'h4); chk({15'h0, wave_out_b}, 16'h0001);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h11); @(negedge mclk); chk({15'h0, wave_out_b}, 16'h0000);
        // channel b, phase correct 8-bit
        i_cpu.wr(`TCOC_ADR_CTRL_B, 8'h00);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h21);
        i_cpu.wr(`TCOC_ADR_CMPB_L, 8'h40); ev(4'h4); chk({15'h0, wave_out_b}, 16'h0000);
        ev(4'h5); chk({15'h0, wave_out_b}, 16'h0001);
        i_cpu.wr(`TCOC_ADR_CTRL_A, 8'h31); ev(4'h5); chk({15'h0, wave_out_b}, 16'h0000);
        ev(4'h4); chk({15'h0, wave_out_b}, 16'h0001);
        close_out();
    end
endmodule : test_timer16_compare_output_control

`default_nettype wire
